// ### core/abx_regs.svh
/*
  constants for the and / bit set-clear execution block: opcode fields and encodings.
  assumes 12-bit instruction words and an 8-bit data path.
*/
`ifndef ABX_REGS_SVH
`define ABX_REGS_SVH
// ==========================================================
// opcode fields
`define ABX_OP_W 12
`define ABX_DATA_W 8
`define ABX_ADDR_W 5
`define ABX_BIT_W 3
`define ABX_NIB_HI 11
`define ABX_NIB_LO 8
`define ABX_DEST_POS 5
`define ABX_BIT_HI 7
`define ABX_BIT_LO 5
// ==========================================================
// encodings
`define ABX_TOP6_ANDF 6'h05
`define ABX_NIB_ANDL 4'he
`define ABX_NIB_BCLR 4'h4
`define ABX_NIB_BSET 4'h5
`define ABX_ACC_RST 8'h00
`endif

// ### core/abx_pkg.sv
/*
  types for the and / bit set-clear execution block.
  assumes abx_regs.svh for widths.
*/
`include "abx_regs.svh"
package abx_pkg;
  typedef enum logic [4:0]
  {
    ABX_OP_NONE = 5'b00001,
    ABX_OP_ANDF = 5'b00010,
    ABX_OP_ANDL = 5'b00100,
    ABX_OP_BCLR = 5'b01000,
    ABX_OP_BSET = 5'b10000
  } abx_op_t;
endpackage : abx_pkg

// ### core/abx_decode.sv
/*
  combinational opcode decoder for the four instructions.
  assumes a stable opcode for the whole instruction cycle.
*/
`timescale 1ns/1ps
`include "abx_regs.svh"
module abx_decode (
  input wire logic [`ABX_OP_W-1:0] opcode,
  output abx_pkg::abx_op_t op,
  output logic [`ABX_ADDR_W-1:0] addr,
  output logic [`ABX_BIT_W-1:0] bit_idx,
  output logic dest_file
);
  always_comb
  begin
    addr = opcode[`ABX_ADDR_W-1:0];
    bit_idx = opcode[`ABX_BIT_HI:`ABX_BIT_LO];
    dest_file = opcode[`ABX_DEST_POS];
    op = abx_pkg::ABX_OP_NONE;
    if (opcode[11:6] == `ABX_TOP6_ANDF)
      op = abx_pkg::ABX_OP_ANDF;
    else if (opcode[`ABX_NIB_HI:`ABX_NIB_LO] == `ABX_NIB_ANDL)
      op = abx_pkg::ABX_OP_ANDL;
    else if (opcode[`ABX_NIB_HI:`ABX_NIB_LO] == `ABX_NIB_BCLR)
      op = abx_pkg::ABX_OP_BCLR;
    else if (opcode[`ABX_NIB_HI:`ABX_NIB_LO] == `ABX_NIB_BSET)
      op = abx_pkg::ABX_OP_BSET;
  end
endmodule : abx_decode

// ### core/abx_exec.sv
/*
  execution of and-with-file, and-literal-into-acc, bit clear and bit set in file.
  assumes the register file returns file_rdata combinationally for file_addr in the same
  cycle, and commits file_we/file_wdata at the next edge.
*/
`timescale 1ns/1ps
`include "abx_regs.svh"
module abx_exec #(
  parameter int DATA_W = `ABX_DATA_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire logic [`ABX_OP_W-1:0] opcode,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic [DATA_W-1:0] acc_wr_data,
  input wire logic acc_wr,
  output logic [`ABX_ADDR_W-1:0] file_addr,
  output logic file_we,
  output logic [DATA_W-1:0] file_wdata,
  output logic [DATA_W-1:0] acc_q,
  output logic zero_q,
  output logic zero_we
);
  // ==========================================================
  // checks
  if (DATA_W != 8)
  begin : g_bad_w
    $error("abx_exec: data width must be 8");
  end

  // ==========================================================
  // decode
  abx_pkg::abx_op_t op;
  logic [`ABX_ADDR_W-1:0] addr;
  logic [`ABX_BIT_W-1:0] bit_idx;
  logic dest_file;

  abx_decode u_dec (
    .opcode(opcode),
    .op(op),
    .addr(addr),
    .bit_idx(bit_idx),
    .dest_file(dest_file)
  );

  // file read address goes straight out so the read happens this cycle
  assign file_addr = addr;

  // ==========================================================
  // datapath
  logic [DATA_W-1:0] and_f;
  logic [DATA_W-1:0] and_l;
  logic [DATA_W-1:0] bmask;
  logic [DATA_W-1:0] acc_d;
  logic zero_d;
  logic zero_we_d;
  logic file_we_d;
  logic [DATA_W-1:0] file_wdata_d;
  logic file_we_q;
  logic [DATA_W-1:0] file_wdata_q;

  always_comb
  begin
    and_f = acc_q & file_rdata;
    and_l = acc_q & opcode[DATA_W-1:0];
    bmask = DATA_W'(1) << bit_idx;
    acc_d = acc_q;
    zero_d = zero_q;
    zero_we_d = 1'b0;
    file_we_d = 1'b0;
    file_wdata_d = file_wdata_q;
    if (acc_wr)
      acc_d = acc_wr_data;
    if (op_valid)
    begin
      case (op)
        abx_pkg::ABX_OP_ANDF:
        begin
          zero_d = (and_f == '0);
          zero_we_d = 1'b1;
          if (dest_file)
          begin
            file_we_d = 1'b1;
            file_wdata_d = and_f;
          end
          else
            acc_d = and_f;
        end
        abx_pkg::ABX_OP_ANDL:
        begin
          acc_d = and_l;
          zero_d = (and_l == '0);
          zero_we_d = 1'b1;
        end
        abx_pkg::ABX_OP_BCLR:
        begin
          file_we_d = 1'b1;
          file_wdata_d = file_rdata & ~bmask;
        end
        abx_pkg::ABX_OP_BSET:
        begin
          file_we_d = 1'b1;
          file_wdata_d = file_rdata | bmask;
        end
        default:
        begin
          file_we_d = 1'b0;
        end
      endcase
    end
  end

  // acc and zero commit at the edge ending the instruction cycle; the file write is registered there and lands one edge later
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      acc_q <= `ABX_ACC_RST;
      zero_q <= 1'b0;
      zero_we <= 1'b0;
      file_we_q <= 1'b0;
      file_wdata_q <= '0;
    end
    else
    begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      zero_we <= zero_we_d;
      file_we_q <= file_we_d;
      file_wdata_q <= file_wdata_d;
    end
  end

  assign file_we = file_we_q;
  assign file_wdata = file_wdata_q;

  // ==========================================================
  // checks on behaviour
  logic [DATA_W-1:0] acc_p;
  logic [DATA_W-1:0] rd_p;
  logic [`ABX_OP_W-1:0] op_p;
  always_ff @(posedge clk)
  begin
    acc_p <= acc_q;
    rd_p <= file_rdata;
    op_p <= opcode;
  end

  sequence s_issue(abx_pkg::abx_op_t o);
    op_valid && !acc_wr && op == o;
  endsequence

  property p_andf_zero;
    @(posedge clk) disable iff (!rst_b)
    s_issue(abx_pkg::ABX_OP_ANDF) |=> zero_we && zero_q == ((acc_p & rd_p) == 8'h00);
  endproperty
  a_andf_zero: assert property (p_andf_zero) else $error("and file zero wrong");

  property p_andf_acc;
    @(posedge clk) disable iff (!rst_b)
    s_issue(abx_pkg::ABX_OP_ANDF) && !dest_file |=> !file_we && acc_q == (acc_p & rd_p);
  endproperty
  a_andf_acc: assert property (p_andf_acc) else $error("and to acc wrong");

  property p_andf_file;
    @(posedge clk) disable iff (!rst_b)
    s_issue(abx_pkg::ABX_OP_ANDF) && dest_file |=>
      file_we && file_wdata == (acc_p & rd_p) && acc_q == acc_p;
  endproperty
  a_andf_file: assert property (p_andf_file) else $error("and to file wrong");

  property p_andl;
    @(posedge clk) disable iff (!rst_b)
    s_issue(abx_pkg::ABX_OP_ANDL) |=>
      acc_q == (acc_p & op_p[7:0]) && zero_q == (acc_q == 8'h00) && !file_we;
  endproperty
  a_andl: assert property (p_andl) else $error("and literal wrong");

  property p_bclr;
    @(posedge clk) disable iff (!rst_b)
    s_issue(abx_pkg::ABX_OP_BCLR) |=> file_we && !zero_we && acc_q == acc_p
      && file_wdata == (rd_p & ~(8'h01 << op_p[7:5]));
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong");

  property p_bset;
    @(posedge clk) disable iff (!rst_b)
    s_issue(abx_pkg::ABX_OP_BSET) |=> file_we && !zero_we && acc_q == acc_p
      && file_wdata == (rd_p | (8'h01 << op_p[7:5]));
  endproperty
  a_bset: assert property (p_bset) else $error("bit set wrong");

  // bit operations must leave the zero flag exactly as it was
  property p_bit_flags;
    @(posedge clk) disable iff (!rst_b)
    op_valid && (op == abx_pkg::ABX_OP_BCLR || op == abx_pkg::ABX_OP_BSET) |=>
      !zero_we && zero_q == $past(zero_q);
  endproperty
  a_bit_flags: assert property (p_bit_flags) else $error("bit op touched zero flag");

  property p_addr;
    @(posedge clk) disable iff (!rst_b)
    file_addr == opcode[4:0] && bit_idx == opcode[7:5];
  endproperty
  a_addr: assert property (p_addr) else $error("field extraction wrong");

  property p_single;
    @(posedge clk) disable iff (!rst_b)
    file_we |=> !file_we || $past(op_valid);
  endproperty
  a_single: assert property (p_single) else $error("write-back not single cycle");
endmodule : abx_exec

// ### verification/abx_file_model.sv
/*
  behavioural data register file on the far side of the execution block.
  assumes writes come one cycle after the issue cycle and commit at the following edge.
*/
`timescale 1ns/1ps
module abx_file_model (
  input wire logic clk,
  input wire logic [4:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  // ==========================================================
  // storage
  logic [7:0] mem [32];
  logic [4:0] waddr_q;
  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 8'(i * 37 + 17);
  end
  // the write address is the read address of the issue cycle, one cycle back
  always @(posedge clk)
  begin
    waddr_q <= file_addr;
    if (file_we)
      mem[waddr_q] <= file_wdata;
  end
  // bypass: a read right behind a write to the same place must see the new byte
  assign file_rdata = (file_we && waddr_q == file_addr) ? file_wdata : mem[file_addr];
endmodule : abx_file_model

// ### verification/and_and_bit_set_clear_exec_tb.sv
/*
  self-checking bench for the execution block: directed corners, then random opcodes.
  assumes the file model above answers reads in the same cycle.
*/
`timescale 1ns/1ps
module and_and_bit_set_clear_exec_tb;
  logic clk, rst_b, op_valid, acc_wr, file_we, zero_q, zero_we, m_z, e_fwe, e_zwe;
  logic [11:0] opcode;
  logic [7:0] file_rdata, acc_wr_data, file_wdata, acc_q, m_acc, m_fwd;
  logic [4:0] file_addr;
  logic [7:0] mem [32];
  logic [31:0] seed;
  logic [3:0] nib [8];
  int n_errors, total_checks;
  abx_exec dut (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .opcode(opcode),
    .file_rdata(file_rdata), .acc_wr_data(acc_wr_data), .acc_wr(acc_wr),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .acc_q(acc_q),
    .zero_q(zero_q), .zero_we(zero_we));
  abx_file_model rf (.clk(clk), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .file_rdata(file_rdata));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // reference: outcome of one issued cycle, seen one cycle later
  task automatic model(input logic v, input logic [11:0] op, input logic aw,
                       input logic [7:0] awd);
    logic [4:0] a;
    logic [7:0] bm, res;
    logic andf, andl, bclr, bset;
    a = op[4:0];
    bm = 8'h01 << op[7:5];
    andf = v && op[11:6] == 6'h05;
    andl = v && op[11:8] == 4'he;
    bclr = v && op[11:8] == 4'h4;
    bset = v && op[11:8] == 4'h5;
    res = bclr ? mem[a] & ~bm : bset ? mem[a] | bm : m_acc & (andl ? op[7:0] : mem[a]);
    e_zwe = andf || andl;
    e_fwe = bclr || bset || (andf && op[5]);
    m_z = e_zwe ? (res == 8'h00) : m_z;
    mem[a] = e_fwe ? res : mem[a];
    m_fwd = e_fwe ? res : m_fwd;
    if (andl || (andf && !op[5]))
      m_acc = res;
    else if (aw)
      m_acc = awd;
  endtask : model
  task automatic step(input logic v, input logic [11:0] op, input logic aw,
                      input logic [7:0] awd);
    @(posedge clk);
    op_valid <= v;
    opcode <= op;
    acc_wr <= aw;
    acc_wr_data <= awd;
    @(negedge clk);
    chk(acc_q, m_acc);
    chk({7'h00, zero_q}, {7'h00, m_z});
    chk({7'h00, zero_we}, {7'h00, e_zwe});
    chk({7'h00, file_we}, {7'h00, e_fwe});
    chk(file_wdata, m_fwd);
    chk({3'h0, file_addr}, {3'h0, op[4:0]});
    model(v, op, aw, awd);
  endtask : step
  // ==========================================================
  // stimulus
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #10000;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    logic [11:0] op;
    for (int i = 0; i < 32; i++)
      mem[i] = 8'(i * 37 + 17);
    nib = '{4'h1, 4'he, 4'h4, 4'h5, 4'h1, 4'h3, 4'hc, 4'h0};
    {rst_b, op_valid, acc_wr, opcode, acc_wr_data} = '0;
    {m_acc, m_z, m_fwd, e_fwe, e_zwe, n_errors, total_checks} = '0;
    seed = 32'h6326ddca;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    step(1'b0, 12'h000, 1'b1, 8'ha3);
    step(1'b1, 12'he5f, 1'b0, 8'h00);
    step(1'b1, 12'h4e5, 1'b0, 8'h00);
    step(1'b1, 12'h5e5, 1'b0, 8'h00);
    step(1'b1, 12'h145, 1'b0, 8'h00);
    step(1'b1, 12'h17f, 1'b0, 8'h00);
    step(1'b1, 12'he00, 1'b0, 8'h00);
    for (int i = 0; i < 400; i++)
    begin
      seed = xs(seed);
      op = {nib[seed[2:0]], seed[15:8]};
      op[7:6] = (seed[2:0] == 3'h0) ? 2'b01 : op[7:6];
      step(seed[2:0] != 3'h7, op, seed[16], seed[31:24]);
    end
    end_of_test();
  end
endmodule : and_and_bit_set_clear_exec_tb
